// file: src/fws_pkg.sv
// package: constants, types and register map of the flash command host
package fws_pkg;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int unsigned CLK_MHZ    = 100;
   localparam int unsigned WE_LOW_NS  = 40;
   localparam int unsigned OE_LOW_NS  = 70;
   localparam int unsigned SYNC_CYC   = 3;
   localparam int unsigned WE_LOW_CYC = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned OE_LOW_CYC = (OE_LOW_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC;

   // ************************************************************
   // register map and fields
   // ************************************************************
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_ADDR   = 8'h04;
   localparam logic [7:0] OFS_WDATA  = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_RDATA  = 8'h10;
   localparam int ST_BUSY     = 0;
   localparam int ST_REFUSED  = 1;
   localparam int ST_FAIL     = 2;
   localparam int ST_TOGGLING = 3;
   localparam int ST_RDY      = 4;
   localparam int ST_AUTOSEL  = 5;
   localparam int ST_BYPASS   = 6;
   localparam int ST_ERASING  = 7;
   localparam int ST_SUSP     = 8;
   localparam int BANK_LSB    = 12;
   localparam int BIT_TOG     = 6;
   localparam int BIT_FAIL    = 5;

   // ************************************************************
   // command cycle values
   // ************************************************************
   localparam logic [10:0] UNLK_A1   = 11'h555;
   localparam logic [10:0] UNLK_A2   = 11'h2aa;
   localparam logic [10:0] CFI_A     = 11'h055;
   localparam logic [7:0]  UNLK_D1   = 8'haa;
   localparam logic [7:0]  UNLK_D2   = 8'h55;
   localparam logic [7:0]  C_RESET   = 8'hf0;
   localparam logic [7:0]  C_PROG    = 8'ha0;
   localparam logic [7:0]  C_ERASE   = 8'h80;
   localparam logic [7:0]  C_SECT    = 8'h30;
   localparam logic [7:0]  C_CHIP    = 8'h10;
   localparam logic [7:0]  C_SUSP    = 8'hb0;
   localparam logic [7:0]  C_RESUME  = 8'h30;
   localparam logic [7:0]  C_AUTOSEL = 8'h90;
   localparam logic [7:0]  C_BYP     = 8'h20;
   localparam logic [7:0]  C_BYP_X2  = 8'h00;
   localparam logic [7:0]  C_CFI     = 8'h98;
   localparam logic [7:0]  C_UNPROT  = 8'h77;

   typedef enum logic [3:0] {
      OP_READ = 4'h0, OP_RESET = 4'h1, OP_PROG = 4'h2, OP_SECT = 4'h3,
      OP_CHIP = 4'h4, OP_SUSP = 4'h5, OP_RESUME = 4'h6, OP_AUTOSEL = 4'h7,
      OP_BYP_ENTRY = 4'h8, OP_BYP_PROG = 4'h9, OP_BYP_RESET = 4'ha,
      OP_CFI = 4'hb, OP_UNPROT = 4'hc, OP_POLL = 4'hd
   } fws_op_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_SETUP = 3'b001, S_STROBE = 3'b010, S_HOLD = 3'b011,
      S_END = 3'b100
   } fws_state_t;

   typedef struct packed {
      logic        ce_n;
      logic        we_n;
      logic        oe_n;
      logic [19:0] addr;
      logic [15:0] dq_o;
      logic        dq_oe;
   } fws_pins_t;

   typedef struct packed {
      logic        last;
      logic        rd;
      logic        full_a;
      logic        ba;
      logic        pd;
      logic [10:0] a;
      logic [7:0]  d;
   } fws_cyc_t;

   typedef struct packed {
      fws_state_t  st;
      fws_op_t     op;
      logic [2:0]  idx;
      logic [3:0]  cnt;
      fws_pins_t   pins;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [15:0] prv;
      logic [2:0]  pn;
      logic        refused;
      logic        fail;
      logic        pbusy;
      logic        autosel;
      logic        bypass;
      logic        erase_on;
      logic        sect;
      logic        susp;
      logic        done;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } fws_st_t;

   localparam fws_st_t ST_RESET = '{st: S_IDLE, op: OP_READ,
      pins: '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 20'h00000, dq_o: 16'h0000,
              dq_oe: 1'b0},
      default: '0};

endpackage : fws_pkg

// file: src/fws_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module fws_sync3 #(
   parameter int W = 17
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_s_b,
   input  wire logic [W-1:0] d_in,
   output logic [W-1:0]      q_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } fws_sync_t;

   fws_sync_t r;
   fws_sync_t n;

   // stage one feeds only stage two; a bit moves once stages two and three agree
   always_comb begin
      n    = r;
      n.s1 = d_in;
      n.s2 = r.s1;
      n.s3 = r.s2;
      for (int i = 0; i < W; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            n.q[i] = r.s3[i];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_s_b) begin
      if (!rst_s_b) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign q_out = r.q;

endmodule : fws_sync3

// file: src/fws_host_ctrl.sv
// host controller that issues flash command sequences and reads back status
`timescale 1ns/1ps
//
// Contract
// R1 - address set up before write strobe falls, held through the cycle
// R2 - write data held steady until after write strobe rises
// R3 - sector erase and verify take sector bits from upper address
// R4 - every command cycle is a write except plain read and autoselect fourth
// R5 - upper data byte driven zero on command cycles
// R6 - upper address bits zero unless bank or sector is needed
// R7 - reset command leaves autoselect and follows a timing failure
// R8 - autoselect fourth cycle is a read carrying the bank address
// R9 - protect verify read returns 00h or 01h, passed through as read data
// R10 - bypass program only after bypass entry; bypass reset leaves bypass
// R11 - suspend only during sector erase, with bank address; limited ops while suspended
// R12 - query command only when not erasing
// R13 - unprotect may persist under suspend; host keeps no unprotect state
// R14 - polling bit shows inverse of written bit while programming
// R15 - protected program target shows brief busy status then array data
// R16 - polling bit zero while erasing, one after erase or suspend
// R17 - all-protected erase shows busy status then array reads
// R18 - after toggling stops, re-read before trusting the data byte
// R19 - ready/busy low while program or erase is active
// R20 - toggle bit one flips on each read while operation runs
// R21 - toggle bit one stops in suspend, runs again for suspended program
// R22 - toggle bit one valid from final write strobe rise
// R23 - toggle bit two flips for sectors selected for erase
// R24 - bit five high marks a timing failure
// R25 - bit three high once erase time-out expires
// R26 - status appears only for reads to the busy bank
module fws_host_ctrl (
   input  wire logic                ref_clk,
   input  wire logic                rst_b,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   output fws_pkg::fws_pins_t       flash_o,
   input  wire logic [15:0]         dq_i,
   input  wire logic                ready_busy_out
);
   // ************************************************************
   // reset release and pin synchronisers
   // ************************************************************
   logic [1:0]       rst_q;
   logic             rst_s_b;
   logic [16:0]      pin_s;
   fws_pkg::fws_st_t r;
   fws_pkg::fws_st_t n;
   fws_pkg::fws_cyc_t cy;
   logic [19:0]      ca;
   logic [15:0]      cd;
   logic             wr;
   fws_pkg::fws_op_t wop;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_s_b = rst_q[1];

   fws_sync3 #(.W(17)) u_sync (
      .ref_clk (ref_clk),
      .rst_s_b (rst_s_b),
      .d_in    ({ready_busy_out, dq_i}),
      .q_out   (pin_s)
   );

   // ************************************************************
   // command cycle table
   // ************************************************************
   function automatic fws_pkg::fws_cyc_t cyc_of(input fws_pkg::fws_op_t op,
                                                input logic [2:0] i);
      fws_pkg::fws_cyc_t c;
      c = '0;
      if (i == 3'd0 || i == 3'd3) begin
         c.a = fws_pkg::UNLK_A1;
         c.d = fws_pkg::UNLK_D1;
      end else if (i == 3'd1 || i == 3'd4) begin
         c.a = fws_pkg::UNLK_A2;
         c.d = fws_pkg::UNLK_D2;
      end else if (i == 3'd2) begin
         c.a = fws_pkg::UNLK_A1;
      end
      case (op)
         fws_pkg::OP_READ, fws_pkg::OP_POLL: begin
            c = '{last: 1'b1, rd: 1'b1, full_a: 1'b1, default: '0};
         end
         fws_pkg::OP_RESET: begin
            c = '{last: 1'b1, d: fws_pkg::C_RESET, default: '0};
         end
         fws_pkg::OP_PROG: begin
            if (i == 3'd2) c.d = fws_pkg::C_PROG;
            if (i == 3'd3) c = '{last: 1'b1, full_a: 1'b1, pd: 1'b1, default: '0};
         end
         fws_pkg::OP_SECT, fws_pkg::OP_CHIP: begin
            if (i == 3'd2) c.d = fws_pkg::C_ERASE;
            if (i == 3'd5 && op == fws_pkg::OP_SECT) begin // [R3]
               c = '{last: 1'b1, full_a: 1'b1, d: fws_pkg::C_SECT, default: '0};
            end else if (i == 3'd5) begin
               c = '{last: 1'b1, a: fws_pkg::UNLK_A1, d: fws_pkg::C_CHIP, default: '0};
            end
         end
         fws_pkg::OP_SUSP: begin
            c = '{last: 1'b1, ba: 1'b1, d: fws_pkg::C_SUSP, default: '0}; // [R11]
         end
         fws_pkg::OP_RESUME: begin
            c = '{last: 1'b1, d: fws_pkg::C_RESUME, default: '0};
         end
         fws_pkg::OP_AUTOSEL: begin
            if (i == 3'd2) begin
               c.ba = 1'b1;
               c.d  = fws_pkg::C_AUTOSEL;
            end
            if (i == 3'd3) c = '{last: 1'b1, rd: 1'b1, full_a: 1'b1, default: '0}; // [R8]
         end
         fws_pkg::OP_BYP_ENTRY: begin
            if (i == 3'd2) begin
               c.d    = fws_pkg::C_BYP;
               c.last = 1'b1;
            end
         end
         fws_pkg::OP_BYP_PROG: begin
            if (i == 3'd0) c = '{d: fws_pkg::C_PROG, default: '0};
            if (i == 3'd1) c = '{last: 1'b1, full_a: 1'b1, pd: 1'b1, default: '0};
         end
         fws_pkg::OP_BYP_RESET: begin
            if (i == 3'd0) c = '{d: fws_pkg::C_AUTOSEL, default: '0};
            if (i == 3'd1) c = '{last: 1'b1, d: fws_pkg::C_BYP_X2, default: '0};
         end
         fws_pkg::OP_CFI: begin
            c = '{last: 1'b1, a: fws_pkg::CFI_A, d: fws_pkg::C_CFI, default: '0};
         end
         fws_pkg::OP_UNPROT: begin
            if (i == 3'd2) begin
               c.d    = fws_pkg::C_UNPROT;
               c.last = 1'b1;
            end
         end
         default: begin
            c = '{last: 1'b1, default: '0};
         end
      endcase
      return c;
   endfunction : cyc_of

   // which commands the mode flags allow; erase and unprotect persist past reset in the
   // device, so the host only tracks modes it can see end
   function automatic logic op_ok(input fws_pkg::fws_st_t s, input fws_pkg::fws_op_t op);
      logic ok;
      ok = 1'b1;
      if (op == fws_pkg::OP_READ || op == fws_pkg::OP_POLL || op == fws_pkg::OP_RESET) begin
         ok = 1'b1;
      end else if (s.bypass) begin // [R10]
         ok = (op == fws_pkg::OP_BYP_PROG || op == fws_pkg::OP_BYP_RESET);
      end else if (s.autosel) begin // [R7]
         ok = (op == fws_pkg::OP_CFI || op == fws_pkg::OP_AUTOSEL);
      end else if (s.susp) begin // [R11]
         ok = (op == fws_pkg::OP_PROG || op == fws_pkg::OP_AUTOSEL ||
               op == fws_pkg::OP_RESUME);
      end else if (s.erase_on) begin // [R11] [R12]
         ok = (op == fws_pkg::OP_SUSP && s.sect);
      end else begin
         ok = (op != fws_pkg::OP_BYP_PROG && op != fws_pkg::OP_BYP_RESET &&
               op != fws_pkg::OP_SUSP && op != fws_pkg::OP_RESUME);
      end
      return ok;
   endfunction : op_ok

   // ************************************************************
   // next state
   // ************************************************************
   assign cy  = cyc_of(r.op, r.idx);
   assign ca  = cy.full_a ? r.addr :
                (cy.ba ? {r.addr[19:fws_pkg::BANK_LSB], 1'b0, cy.a} : {9'h000, cy.a}); // [R6]
   assign cd  = cy.pd ? r.wdata : {8'h00, cy.d}; // [R5]
   assign wr  = psel && penable && r.pready && pwrite;
   assign wop = fws_pkg::fws_op_t'(pwdata[3:0]);

   always_comb begin
      n        = r;
      n.done   = 1'b0;
      n.pready = 1'b0;
      if (psel && !penable) begin
         n.pready  = 1'b1;
         n.pslverr = 1'b0;
         n.prdata  = 32'h00000000;
         if (paddr == fws_pkg::OFS_CTRL) begin
            n.prdata = {28'h0000000, r.op};
         end else if (paddr == fws_pkg::OFS_ADDR) begin
            n.prdata = {12'h000, r.addr};
         end else if (paddr == fws_pkg::OFS_WDATA) begin
            n.prdata = {16'h0000, r.wdata};
         end else if (paddr == fws_pkg::OFS_STATUS) begin
            n.prdata[fws_pkg::ST_BUSY]     = (r.st != fws_pkg::S_IDLE);
            n.prdata[fws_pkg::ST_REFUSED]  = r.refused;
            n.prdata[fws_pkg::ST_FAIL]     = r.fail;
            n.prdata[fws_pkg::ST_TOGGLING] = r.pbusy;
            n.prdata[fws_pkg::ST_RDY]      = pin_s[16]; // [R19]
            n.prdata[fws_pkg::ST_AUTOSEL]  = r.autosel;
            n.prdata[fws_pkg::ST_BYPASS]   = r.bypass;
            n.prdata[fws_pkg::ST_ERASING]  = r.erase_on;
            n.prdata[fws_pkg::ST_SUSP]     = r.susp;
         end else if (paddr == fws_pkg::OFS_RDATA) begin
            n.prdata = {16'h0000, r.rdata}; // [R9]
         end else begin
            n.pslverr = 1'b1;
         end
      end
      if (wr && paddr == fws_pkg::OFS_ADDR) begin
         n.addr = pwdata[19:0];
      end else if (wr && paddr == fws_pkg::OFS_WDATA) begin
         n.wdata = pwdata[15:0];
      end else if (wr && paddr == fws_pkg::OFS_CTRL && r.st == fws_pkg::S_IDLE) begin
         // a command written while a sequence runs is dropped and flagged
         n.refused = !op_ok(r, wop);
         if (op_ok(r, wop)) begin
            n.op  = wop;
            n.idx = 3'd0;
            n.pn  = 3'd0;
            n.st  = fws_pkg::S_SETUP;
            if (wop == fws_pkg::OP_POLL) begin
               n.fail  = 1'b0;
               n.pbusy = 1'b0;
            end
         end
      end else if (wr && paddr == fws_pkg::OFS_CTRL) begin
         n.refused = 1'b1;
      end

      case (r.st)
         fws_pkg::S_SETUP: begin // [R1]
            n.pins.ce_n  = 1'b0;
            n.pins.addr  = ca;
            n.pins.dq_o  = cd;
            n.pins.dq_oe = !cy.rd; // [R4]
            // strobe stays low for exactly the loaded count of cycles
            n.cnt        = cy.rd ? 4'(fws_pkg::OE_LOW_CYC) : 4'(fws_pkg::WE_LOW_CYC);
            n.st         = fws_pkg::S_STROBE;
         end
         fws_pkg::S_STROBE: begin
            n.pins.oe_n = !cy.rd;
            n.pins.we_n = cy.rd;
            n.cnt       = r.cnt - 4'd1;
            if (r.cnt == 4'd0) begin
               n.pins.oe_n = 1'b1;
               n.pins.we_n = 1'b1; // [R2]
               n.st        = fws_pkg::S_HOLD;
               if (cy.rd) n.rdata = pin_s[15:0];
            end
         end
         fws_pkg::S_HOLD: begin
            n.pins.ce_n  = 1'b1;
            n.pins.dq_oe = 1'b0;
            n.st         = fws_pkg::S_END;
         end
         fws_pkg::S_END: begin
            n.st = fws_pkg::S_SETUP;
            n.pn = r.pn + 3'd1;
            if (r.op == fws_pkg::OP_POLL) begin // [R20] [R24]
               if (r.pn == 3'd0 || r.pn == 3'd2) begin
                  n.prv = r.rdata;
               end else if (r.prv[fws_pkg::BIT_TOG] == r.rdata[fws_pkg::BIT_TOG] &&
                            r.pn != 3'd4) begin
                  n.pn = 3'd4; // [R18]
               end else if (r.pn == 3'd1 && r.rdata[fws_pkg::BIT_FAIL]) begin
                  n.pn = 3'd2;
               end else if (r.pn == 3'd1) begin
                  n.pbusy = 1'b1;
                  n.done  = 1'b1;
                  n.st    = fws_pkg::S_IDLE;
               end else if (r.pn == 3'd3) begin
                  n.fail = 1'b1; // [R7]
                  n.op   = fws_pkg::OP_RESET;
                  n.idx  = 3'd0;
               end else begin
                  n.done = 1'b1;
                  n.st   = fws_pkg::S_IDLE;
                  if (!r.susp) begin
                     n.erase_on = 1'b0;
                     n.sect     = 1'b0;
                  end
               end
            end else if (!cy.last) begin
               n.idx = r.idx + 3'd1;
            end else begin
               n.done = 1'b1;
               n.st   = fws_pkg::S_IDLE;
               case (r.op)
                  fws_pkg::OP_RESET:     n.autosel = 1'b0; // [R7]
                  fws_pkg::OP_AUTOSEL:   n.autosel = 1'b1;
                  fws_pkg::OP_BYP_ENTRY: n.bypass  = 1'b1; // [R10]
                  fws_pkg::OP_BYP_RESET: n.bypass  = 1'b0; // [R10]
                  fws_pkg::OP_SECT: begin
                     n.erase_on = 1'b1;
                     n.sect     = 1'b1;
                  end
                  fws_pkg::OP_CHIP:   n.erase_on = 1'b1;
                  fws_pkg::OP_SUSP:   n.susp     = 1'b1; // [R11]
                  fws_pkg::OP_RESUME: n.susp     = 1'b0;
                  default:            n.done     = 1'b1;
               endcase
            end
         end
         fws_pkg::S_IDLE: begin
            // a command accepted above leaves idle from here
         end
         default: begin
            n.st = fws_pkg::S_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_s_b) begin
      if (!rst_s_b) begin
         r <= fws_pkg::ST_RESET;
      end else begin
         r <= n;
      end
   end

   assign prdata  = r.prdata;
   assign pready  = r.pready;
   assign pslverr = r.pslverr;
   assign flash_o = r.pins;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_s_b);

   property p_addr_first;
      $fell(flash_o.we_n) |-> !flash_o.ce_n && $stable(flash_o.addr);
   endproperty
   a_addr_first: assert property (p_addr_first) else $error("address moved at strobe"); // [R1]

   property p_data_hold;
      $rose(flash_o.we_n) |-> !flash_o.ce_n && flash_o.dq_oe && $stable(flash_o.dq_o)
                              ##1 flash_o.ce_n;
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("data not held past strobe"); // [R2]

   property p_read_only_oe;
      !flash_o.oe_n |-> flash_o.we_n && !flash_o.dq_oe && (cy.rd);
   endproperty
   a_read_only_oe: assert property (p_read_only_oe) else $error("read cycle misdriven"); // [R4]

   property p_hi_byte;
      (!flash_o.we_n && !cy.pd) |-> flash_o.dq_o[15:8] == 8'h00;
   endproperty
   a_hi_byte: assert property (p_hi_byte) else $error("upper byte driven on command"); // [R5]

   property p_reset_exit;
      (r.done && r.op == fws_pkg::OP_RESET) |-> !r.autosel;
   endproperty
   a_reset_exit: assert property (p_reset_exit) else $error("autoselect kept after reset"); // [R7]

   property p_bank_read;
      (!flash_o.oe_n && r.op == fws_pkg::OP_AUTOSEL) |-> r.idx == 3'd3 && flash_o.addr == r.addr;
   endproperty
   a_bank_read: assert property (p_bank_read) else $error("autoselect read misplaced"); // [R8]

   property p_bypass_prog;
      (r.st != fws_pkg::S_IDLE && r.op == fws_pkg::OP_BYP_PROG) |-> r.bypass;
   endproperty
   a_bypass_prog: assert property (p_bypass_prog) else $error("bypass program outside bypass"); // [R10]

   property p_suspend;
      (!flash_o.we_n && r.op == fws_pkg::OP_SUSP) |->
         r.sect && flash_o.addr[19:12] == r.addr[19:12] ##[1:8] r.susp;
   endproperty
   a_suspend: assert property (p_suspend) else $error("bad erase suspend"); // [R11]

   property p_reread;
      (r.done && r.op == fws_pkg::OP_POLL && !r.pbusy) |-> r.pn == 3'd5;
   endproperty
   a_reread: assert property (p_reread) else $error("poll finished without re-read"); // [R18]

   c_poll_ok:   cover property (r.done && r.op == fws_pkg::OP_POLL && !r.pbusy);
   c_poll_fail: cover property (r.done && r.fail);
   c_suspend:   cover property (r.done && r.op == fws_pkg::OP_SUSP);
   c_autosel:   cover property (r.done && r.op == fws_pkg::OP_AUTOSEL);

endmodule : fws_host_ctrl

// file: sim/fws_flash_model.sv
// behavioural flash device seen at the host's pins
`timescale 1ns/1ps
module fws_flash_model #(
   parameter int BUSY_RD = 3
) (
   input  fws_pkg::fws_pins_t pins,
   output logic [15:0] dq,
   output logic        rb
);
   logic [19:0] la, pa;
   logic [15:0] ld, pd, last, val;
   logic [1:0]  n;
   logic        prog, tog;
   int          busy;
   initial begin
      {la, pa, ld, pd, last, n, prog, tog, busy} = '0;
   end
   always @(negedge pins.we_n) if (!pins.ce_n) la = pins.addr;
   always @(posedge pins.we_n) if (!pins.ce_n) begin
      ld = pins.dq_o;
      if (prog) begin
         {pa, pd, prog, busy} = {la, ld, 1'b0, BUSY_RD};
      end else if (ld[7:0] == fws_pkg::UNLK_D1) n = 2'd1;
      else if (n == 2'd1 && ld[7:0] == fws_pkg::UNLK_D2) n = 2'd2;
      else begin
         prog = (n == 2'd2 && ld[7:0] == fws_pkg::C_PROG);
         n = 2'd0;
      end
   end
   // each read while busy flips the toggle bit, from the first read on
   always @(negedge pins.oe_n) if (!pins.ce_n && busy > 0) begin
      tog = ~tog;
      busy--;
   end
   assign val = (busy > 0) ? {8'h00, ~pd[7], tog, 6'h00} : pd;
   // released bus shows the inverse of the last value, never a held copy
   always @(posedge pins.oe_n) last = val;
   assign dq = (!pins.ce_n && !pins.oe_n) ? val : ~last;
   assign rb = !(busy > 0);
endmodule : fws_flash_model

// file: sim/tb_flash_write_status_reporting.sv
// testbench: apb sequences against the host controller and flash model
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); fail_count++; end end
module tb_flash_write_status_reporting;
   logic               ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, rb;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, r;
   logic [15:0]        dq;
   fws_pkg::fws_pins_t pins;
   int                 fail_count, samples_checked, cyc;
   logic [3:0]         refused_ops [4] = '{4'h5, 4'h6, 4'h9, 4'ha};
   fws_host_ctrl DUT (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_o(pins), .dq_i(dq), .ready_busy_out(rb));
   fws_flash_model m (.pins(pins), .dq(dq), .rb(rb));
   always #5 ref_clk = ~ref_clk;
   // ************************************************************
   // bus tasks
   // ************************************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      r = prdata;
      {psel, penable} <= 2'b00;
   endtask : apb
   // bounded wait: the cycle ceiling ends a hang
   task automatic wait_idle();
      do apb(0, fws_pkg::OFS_STATUS, 0); while (r[fws_pkg::ST_BUSY] !== 1'b0);
   endtask : wait_idle
   task automatic end_of_test();
      $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 50000) begin
         fail_count++;
         end_of_test();
      end
   end
   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      {ref_clk, rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
      {fail_count, samples_checked, cyc} = '0;
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      // internal reset and the pin synchroniser need a few edges to settle
      repeat (8) @(posedge ref_clk);
      apb(0, fws_pkg::OFS_STATUS, 0);
      `CHK(r[fws_pkg::ST_RDY], 1'b1)
      apb(0, 8'h40, 0);
      `CHK(pslverr, 1'b1)
      foreach (refused_ops[i]) begin
         apb(1, fws_pkg::OFS_CTRL, {28'h0, refused_ops[i]});
         wait_idle();
         `CHK(r[fws_pkg::ST_REFUSED], 1'b1)
      end
      apb(1, fws_pkg::OFS_ADDR, 32'h00003456);
      apb(1, fws_pkg::OFS_WDATA, 32'h00005aa5);
      apb(1, fws_pkg::OFS_CTRL, 32'h2);
      wait_idle();
      `CHK(r[fws_pkg::ST_RDY], 1'b0)
      `CHK(m.pa, 20'h03456)
      `CHK(m.pd, 16'h5aa5)
      apb(1, fws_pkg::OFS_CTRL, 32'hd);
      wait_idle();
      `CHK(r[fws_pkg::ST_TOGGLING], 1'b1)
      apb(0, fws_pkg::OFS_RDATA, 0);
      `CHK(r[7], 1'b0)
      apb(1, fws_pkg::OFS_CTRL, 32'hd);
      wait_idle();
      `CHK(r[fws_pkg::ST_TOGGLING], 1'b0)
      `CHK(r[fws_pkg::ST_RDY], 1'b1)
      apb(0, fws_pkg::OFS_RDATA, 0);
      `CHK(r[15:0], 16'h5aa5)
      apb(1, fws_pkg::OFS_CTRL, 32'h8);
      wait_idle();
      `CHK(r[fws_pkg::ST_BYPASS], 1'b1)
      apb(1, fws_pkg::OFS_CTRL, 32'h2);
      wait_idle();
      `CHK(r[fws_pkg::ST_REFUSED], 1'b1)
      apb(1, fws_pkg::OFS_CTRL, 32'ha);
      wait_idle();
      `CHK(r[fws_pkg::ST_BYPASS], 1'b0)
      apb(1, fws_pkg::OFS_CTRL, 32'h7);
      wait_idle();
      `CHK(r[fws_pkg::ST_AUTOSEL], 1'b1)
      apb(1, fws_pkg::OFS_CTRL, 32'h1);
      wait_idle();
      `CHK(r[fws_pkg::ST_AUTOSEL], 1'b0)
      end_of_test();
   end
endmodule : tb_flash_write_status_reporting
